// ### design/uad_consts.svh
// Constants for the address-detecting serial receiver: register indices,
// field positions, reset values and bit-time tick counts.
// Assumes inclusion by bare name from the design files.
`ifndef UAD_CONSTS_SVH
`define UAD_CONSTS_SVH

`define UAD_ADDR_W          3
`define UAD_DATA_W          8
`define UAD_CHAR_W          9

`define UAD_IDX_BAUD_CTRL   3'h0
`define UAD_IDX_RX_DATA     3'h1
`define UAD_IDX_RX_STAT     3'h2
`define UAD_IDX_DIV_LOW     3'h3
`define UAD_IDX_DIV_HIGH    3'h4
`define UAD_IDX_TX_STAT     3'h5
`define UAD_IDX_INT_STAT    3'h6
`define UAD_IDX_INT_MASK    3'h7

`define UAD_RX_PORT_EN      7
`define UAD_RX_NINE_SEL     6
`define UAD_RX_SINGLE_EN    5
`define UAD_RX_CONT_EN      4
`define UAD_RX_ADDR_DET     3
`define UAD_RX_FRAME_ERR    2
`define UAD_RX_OVERRUN      1
`define UAD_RX_NINTH_BIT    0

`define UAD_TX_CLK_SRC      7
`define UAD_TX_NINE_SEL     6
`define UAD_TX_SYNC_MODE    4
`define UAD_TX_HIGH_SPEED   2
`define UAD_TX_SHIFT_EMPTY  1

`define UAD_BC_RX_IDLE      6
`define UAD_BC_WIDE_DIV     3

`define UAD_INT_RX_CHAR     0
`define UAD_INT_OVERRUN     1

`define UAD_RST_BYTE        8'h00
`define UAD_FIFO_DEPTH      2'h2
`define UAD_TICKS_FAST      7'h04
`define UAD_TICKS_MID       7'h10
`define UAD_TICKS_SLOW      7'h40

`endif

// ### design/uad_pkg.sv
// Types shared by the address-detecting serial receiver.
// Assumes the constants header is compiled alongside.
package uad_pkg;
  typedef logic [2:0] uad_addr_t;
  typedef logic [7:0] uad_byte_t;
  typedef logic [8:0] uad_char_t;
  typedef enum logic [3:0]
  {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } uad_rx_state_t;
endpackage

// ### design/uad_baud_gen.sv
// Baud divisor counter: one-cycle tick every divisor+1 clocks (divisor[7:0]+1 with wideDiv clear).
// Assumes a synchronous clear while the serial port is disabled.
`timescale 1ns/1ps
`include "uad_consts.svh"
module uad_baud_gen
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] divisor,
  input  wire logic        wideDiv,
  output logic             baudTick
);
  import uad_pkg::*;

  logic [15:0] countReg;
  logic [15:0] reloadVal;

  assign reloadVal = wideDiv ? divisor : {8'h00, divisor[7:0]};

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      countReg <= 16'h0000;
      baudTick <= 1'b0;
    end
    else
    begin
      baudTick <= (countReg == 16'h0000);
      countReg <= (countReg == 16'h0000) ? reloadVal : countReg - 16'h0001;
    end
  end
endmodule // uad_baud_gen

// ### design/uad_rx_frame.sv
// Character framer: start check at mid bit, data LSB first, stop check.
// Assumes a pin already synchronous to core_clk and a baud tick pulse.
`timescale 1ns/1ps
`include "uad_consts.svh"
module uad_rx_frame
(
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             baudTick,
  input  wire logic             rxPin,
  input  wire logic             rxEnable,
  input  wire logic             nineBit,
  input  wire logic [6:0]       bitTicks,
  output logic                  charValid,
  output uad_pkg::uad_char_t    charData,
  output logic                  charFerr,
  output logic                  rxIdle
);
  import uad_pkg::*;

  uad_rx_state_t stateReg;
  logic [6:0]    tickReg;
  logic [3:0]    bitReg;
  uad_char_t     shiftReg;
  logic          bitDone;

  assign bitDone = baudTick && (tickReg == bitTicks - 7'h01);
  assign rxIdle  = (stateReg == RX_IDLE);

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      stateReg  <= RX_IDLE;
      tickReg   <= 7'h00;
      bitReg    <= 4'h0;
      shiftReg  <= 9'h000;
      charValid <= 1'b0;
      charData  <= 9'h000;
      charFerr  <= 1'b0;
    end
    else
    begin
      charValid <= 1'b0;
      if (baudTick)
        tickReg <= bitDone ? 7'h00 : tickReg + 7'h01;
      case (stateReg)
        RX_IDLE:
        begin
          tickReg <= 7'h00;
          if (rxEnable && !rxPin)
            stateReg <= RX_START;
        end
        RX_START:
        begin
          if (baudTick && tickReg == (bitTicks >> 1) - 7'h01)
          begin
            tickReg  <= 7'h00;
            bitReg   <= 4'h0;
            stateReg <= rxPin ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (bitDone)
          begin
            shiftReg <= {rxPin, shiftReg[8:1]};
            bitReg   <= bitReg + 4'h1;
            if (bitReg == (nineBit ? 4'h8 : 4'h7))
              stateReg <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (bitDone)
          begin
            charValid <= 1'b1;
            charFerr  <= !rxPin;
            charData  <= nineBit ? shiftReg : {1'b0, shiftReg[8:1]};
            stateReg  <= RX_IDLE;
          end
        end
        default:
          stateReg <= RX_IDLE;
      endcase
    end
  end
endmodule // uad_rx_frame

// ### design/uad_top.sv
// Serial receiver with 9-bit address detection and its register file.
// Assumes a single-cycle register port and a line level sync to core_clk.
//
// Notes on behaviour
// RULE1: Address mode flags only ninth-bit-one characters
// RULE2: Interrupt request only with receive enable set (irq is intStatReg masked by intMaskReg only, not gated by portEn)
// RULE3: Software enables interrupts before enabling reception
// RULE4: Ninth bit reads one during address mode
// RULE5: Clearing continuous receive clears overrun flag
// RULE6: Address mode off: every character buffered, flagged
// RULE7: Software follows the documented setup order
// RULE8: Software reads status before data byte
// RULE9: Transmit width bit selects nine or eight
// RULE10: Clock source matters only in synchronous mode
// RULE11: Software keeps synchronous mode clear here
// RULE12: Ninth-bit-zero characters dropped in address mode
// RULE13: Software clears address mode before next stop
// RULE14: Two-deep buffer; third character sets overrun
// RULE15: Available flag read-only, set while unread
// RULE16: Data read pops top, exposes next status
`timescale 1ns/1ps
`include "uad_consts.svh"
module uad_top
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire uad_pkg::uad_addr_t regAddr,
  input  wire uad_pkg::uad_byte_t regWrData,
  input  wire logic              regWrStb,
  input  wire logic              regRdStb,
  output uad_pkg::uad_byte_t     regRdData,
  input  wire logic              rxPin,
  output logic                   rxAvailable,
  output logic                   irq,
  output logic                   txNineBit,
  output logic                   syncClkMaster
);
  import uad_pkg::*;

  uad_byte_t  baudCtrlReg;
  uad_byte_t  rxCtrlReg;
  uad_byte_t  txCtrlReg;
  uad_byte_t  divLowReg;
  uad_byte_t  divHighReg;
  logic [1:0] intStatReg;
  logic [1:0] intStatNext;
  logic [1:0] intMaskReg;
  logic       overrunReg;
  logic [1:0] countReg;
  uad_char_t  slotData [2];
  logic       slotFerr [2];

  logic       portEn;
  logic       contEn;
  logic       addrDet;
  logic       nineSel;
  logic       unitRst;
  logic       baudTick;
  logic [6:0] bitTicks;
  logic       charValid;
  uad_char_t  charData;
  logic       charFerr;
  logic       rxIdle;
  logic       wrHit;
  logic       popReq;
  logic       accepted;
  logic       pushReq;
  logic [1:0] wrIdx;
  logic       ovrSet;
  logic       topNinth;

  assign portEn  = rxCtrlReg[`UAD_RX_PORT_EN];
  assign contEn  = rxCtrlReg[`UAD_RX_CONT_EN];
  assign addrDet = rxCtrlReg[`UAD_RX_ADDR_DET];
  assign nineSel = rxCtrlReg[`UAD_RX_NINE_SEL];
  assign unitRst = sys_rst || !portEn;
  assign wrHit   = regWrStb;

  // Bit time in baud ticks from the speed and width selects
  always_comb
  begin
    if (baudCtrlReg[`UAD_BC_WIDE_DIV] && txCtrlReg[`UAD_TX_HIGH_SPEED])
      bitTicks = `UAD_TICKS_FAST;
    else if (baudCtrlReg[`UAD_BC_WIDE_DIV] || txCtrlReg[`UAD_TX_HIGH_SPEED])
      bitTicks = `UAD_TICKS_MID;
    else
      bitTicks = `UAD_TICKS_SLOW;
  end

  uad_baud_gen u_baud
  (
    .core_clk (core_clk),
    .sys_rst  (unitRst),
    .divisor  ({divHighReg, divLowReg}),
    .wideDiv  (baudCtrlReg[`UAD_BC_WIDE_DIV]),
    .baudTick (baudTick)
  );

  // Reception halts while overrun stands
  uad_rx_frame u_frame
  (
    .core_clk  (core_clk),
    .sys_rst   (unitRst),
    .baudTick  (baudTick),
    .rxPin     (rxPin),
    .rxEnable  (contEn && !overrunReg), // RULE14
    .nineBit   (nineSel),
    .bitTicks  (bitTicks),
    .charValid (charValid),
    .charData  (charData),
    .charFerr  (charFerr),
    .rxIdle    (rxIdle)
  );

  // Control registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      baudCtrlReg <= `UAD_RST_BYTE;
      rxCtrlReg   <= `UAD_RST_BYTE;
      txCtrlReg   <= `UAD_RST_BYTE;
      divLowReg   <= `UAD_RST_BYTE;
      divHighReg  <= `UAD_RST_BYTE;
      intMaskReg  <= 2'h0;
    end
    else if (wrHit)
    begin
      case (regAddr)
        `UAD_IDX_BAUD_CTRL: baudCtrlReg <= regWrData;
        `UAD_IDX_RX_STAT:   rxCtrlReg   <= regWrData;
        `UAD_IDX_TX_STAT:   txCtrlReg   <= regWrData;
        `UAD_IDX_DIV_LOW:   divLowReg   <= regWrData;
        `UAD_IDX_DIV_HIGH:  divHighReg  <= regWrData;
        `UAD_IDX_INT_MASK:  intMaskReg  <= regWrData[1:0];
        default:            intMaskReg  <= intMaskReg;
      endcase
    end
  end

  // Transmit width and synchronous clock role decoded for the transmitter
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      txNineBit     <= 1'b0;
      syncClkMaster <= 1'b0;
    end
    else
    begin
      txNineBit     <= txCtrlReg[`UAD_TX_NINE_SEL]; // RULE9
      syncClkMaster <= txCtrlReg[`UAD_TX_SYNC_MODE] && txCtrlReg[`UAD_TX_CLK_SRC]; // RULE10
    end
  end

  // Buffer admission: address mode with nine-bit reception keeps only ninth-bit-one characters
  assign accepted = !(addrDet && nineSel) || charData[8]; // RULE12 RULE6
  assign popReq   = regRdStb && (regAddr == `UAD_IDX_RX_DATA) && (countReg != 2'h0); // RULE16
  assign pushReq  = charValid && accepted && !overrunReg && portEn;
  assign wrIdx    = countReg - {1'b0, popReq};
  assign ovrSet   = pushReq && (wrIdx == `UAD_FIFO_DEPTH) && contEn; // RULE14

  always_ff @(posedge core_clk)
  begin
    if (unitRst)
      countReg <= 2'h0;
    else if (pushReq && !ovrSet)
      countReg <= wrIdx + 2'h1; // RULE1 RULE6
    else
      countReg <= wrIdx;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_slot
      always_ff @(posedge core_clk)
      begin
        if (unitRst)
        begin
          slotData[gi] <= 9'h000;
          slotFerr[gi] <= 1'b0;
        end
        else if (pushReq && !ovrSet && wrIdx == gi)
        begin
          slotData[gi] <= charData;
          slotFerr[gi] <= charFerr;
        end
        else if (popReq && gi == 0)
        begin
          slotData[gi] <= slotData[1]; // RULE16
          slotFerr[gi] <= slotFerr[1];
        end
      end
    end
  endgenerate

  // Overrun: cleared by dropping continuous receive or the port enable
  always_ff @(posedge core_clk)
  begin
    if (unitRst || !contEn)
      overrunReg <= 1'b0; // RULE5
    else if (ovrSet)
      overrunReg <= 1'b1; // RULE14
  end

  assign rxAvailable = portEn && (countReg != 2'h0); // RULE15 RULE1
  assign topNinth    = addrDet ? 1'b1 : slotData[0][8]; // RULE4

  // Sticky events, write one to clear, a new event wins
  always_comb
  begin
    intStatNext = intStatReg;
    if (wrHit && regAddr == `UAD_IDX_INT_STAT)
      intStatNext = intStatReg & ~regWrData[1:0];
    if (pushReq && !ovrSet)
      intStatNext[`UAD_INT_RX_CHAR] = 1'b1;
    if (ovrSet)
      intStatNext[`UAD_INT_OVERRUN] = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      intStatReg <= 2'h0;
    else
      intStatReg <= intStatNext;
  end

  assign irq = |(intStatReg & intMaskReg); // RULE2

  // Read data, valid the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      regRdData <= `UAD_RST_BYTE;
    else if (regRdStb)
    begin
      case (regAddr)
        `UAD_IDX_BAUD_CTRL: regRdData <= {1'b0, rxIdle, 2'h0, baudCtrlReg[`UAD_BC_WIDE_DIV], 3'h0};
        `UAD_IDX_RX_DATA:   regRdData <= slotData[0][7:0];
        `UAD_IDX_RX_STAT:   regRdData <= {rxCtrlReg[7:3], slotFerr[0], overrunReg, topNinth}; // RULE4
        `UAD_IDX_DIV_LOW:   regRdData <= divLowReg;
        `UAD_IDX_DIV_HIGH:  regRdData <= divHighReg;
        `UAD_IDX_TX_STAT:   regRdData <= {txCtrlReg[7:2], 1'b1, txCtrlReg[0]};
        `UAD_IDX_INT_STAT:  regRdData <= {6'h00, intStatReg};
        `UAD_IDX_INT_MASK:  regRdData <= {6'h00, intMaskReg};
        default:            regRdData <= `UAD_RST_BYTE;
      endcase
    end
    else
      regRdData <= `UAD_RST_BYTE;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_addr_char_zero;
    charValid && addrDet && nineSel && !charData[8];
  endsequence

  sequence s_addr_char_one;
    charValid && addrDet && nineSel && charData[8] && portEn && !overrunReg && countReg == 2'h0;
  endsequence

  a_addr_drop_zero: assert property (s_addr_char_zero ##0 !popReq |=> countReg == $past(countReg)) // RULE12
    else $error("address mode buffered a ninth-bit-zero character");

  a_addr_flag_one: assert property (s_addr_char_one ##1 portEn |-> rxAvailable) // RULE1
    else $error("address character did not raise the available flag");

  a_irq_needs_mask: assert property (pushReq && !ovrSet && intMaskReg[`UAD_INT_RX_CHAR] && !wrHit |=> irq) // RULE2
    else $error("enabled character event raised no interrupt");

  a_ninth_reads_one: assert property (regRdStb && regAddr == `UAD_IDX_RX_STAT && addrDet |=> regRdData[0]) // RULE4
    else $error("ninth bit not one in address mode");

  a_overrun_clear: assert property (!contEn && portEn |=> !overrunReg) // RULE5
    else $error("overrun stayed after continuous receive cleared");

  a_all_pass: assert property (charValid && !addrDet && portEn && !overrunReg && countReg == 2'h1 && !popReq
    |=> countReg == 2'h2 && rxAvailable) // RULE6
    else $error("character lost with address mode off");

  a_overrun_set: assert property (pushReq && countReg == 2'h2 && !popReq && contEn |=> overrunReg [*2]) // RULE14
    else $error("third character did not set overrun");

  a_depth_bound: assert property (countReg <= `UAD_FIFO_DEPTH) // RULE14
    else $error("buffer count beyond two");

  a_pop_advance: assert property (popReq && countReg == 2'h2 && !charValid |=> countReg == 2'h1 && rxAvailable) // RULE16
    else $error("data read did not remove the top character");

  a_flag_drops: assert property (popReq && countReg == 2'h1 && !charValid |=> !rxAvailable) // RULE15
    else $error("available flag stayed with an empty buffer");

  sequence s_push_into_empty;
    pushReq && !ovrSet && !popReq && countReg == 2'h0;
  endsequence

  sequence s_pop_full;
    popReq && !pushReq && countReg == 2'h2;
  endsequence

  sequence s_tx_ctrl_write;
    wrHit && regAddr == `UAD_IDX_TX_STAT;
  endsequence

  a_irq_masked_off: assert property (pushReq && intMaskReg == 2'h0 && !wrHit |=> rxAvailable && !irq) // RULE2
    else $error("masked character raised an interrupt");

  a_top_entry: assert property (s_push_into_empty |=> slotData[0] == $past(charData)) // RULE1
    else $error("received character not at the top of the buffer");

  a_pop_next: assert property (s_pop_full |=> slotData[0] == $past(slotData[1]) && slotFerr[0] == $past(slotFerr[1])) // RULE16
    else $error("data read did not expose the next character");

  a_ovr_blocks: assert property (overrunReg && rxIdle |=> rxIdle) // RULE14
    else $error("reception started while overrun stands");

  a_flag_readonly: assert property (portEn && countReg != 2'h0 && !popReq // RULE15
    && !(wrHit && regAddr == `UAD_IDX_RX_STAT) |=> rxAvailable)
    else $error("available flag fell with an unread character");

  a_tx_width: assert property (s_tx_ctrl_write |-> ##2 txNineBit == $past(regWrData[`UAD_TX_NINE_SEL], 2)) // RULE9
    else $error("transmit width output does not follow its select");

  a_clk_src_async: assert property (!txCtrlReg[`UAD_TX_SYNC_MODE] |=> !syncClkMaster) // RULE10
    else $error("clock source used in asynchronous mode");

  a_clk_src_master: assert property (s_tx_ctrl_write ##0 regWrData[`UAD_TX_SYNC_MODE] // RULE10
    && regWrData[`UAD_TX_CLK_SRC] |-> ##2 syncClkMaster)
    else $error("synchronous master role not selected");

  a_addr_no_flag: assert property (s_addr_char_zero ##0 !wrHit // RULE12
    |=> intStatReg[`UAD_INT_RX_CHAR] == $past(intStatReg[`UAD_INT_RX_CHAR]))
    else $error("dropped character touched the event status");

  a_data_all_flag: assert property (charValid && !addrDet && portEn && !overrunReg && countReg != 2'h2 && !wrHit // RULE6
    |=> intStatReg[`UAD_INT_RX_CHAR])
    else $error("data character raised no event");

  a_ninth_status: assert property (regRdStb && regAddr == `UAD_IDX_RX_STAT && !addrDet // RULE16
    |=> regRdData[`UAD_RX_NINTH_BIT] == $past(slotData[0][8]))
    else $error("ninth bit status not that of the top character");

  a_framing_error_status: assert property (regRdStb && regAddr == `UAD_IDX_RX_STAT // RULE16
    |=> regRdData[`UAD_RX_FRAME_ERR] == $past(slotFerr[0]))
    else $error("framing status not that of the top character");

  a_rd_idle_zero: assert property (!regRdStb |=> regRdData == `UAD_RST_BYTE)
    else $error("read data not zero outside a read");
endmodule // uad_top

// ### bench/uad_line_model.sv
// Remote transmitter on the shared receive line.
// Assumes the bench calls send; the line idles high between frames.
`timescale 1ns/1ps
module uad_line_model
#(
  parameter int BIT_CLK = 8
)
(
  input  wire logic core_clk,
  output logic      rxPin
);
  initial rxPin = 1'b1;

  // Start bit, data LSB first, stop bit, then two idle bits for nine-bit frames, three for eight-bit
  task automatic send(input logic [8:0] ch, input logic nine, input logic stopLvl, input int bitLen);
    logic [12:0] fr;
    fr = nine ? {2'b11, stopLvl, ch, 1'b0} : {3'b111, stopLvl, ch[7:0], 1'b0};
    for (int i = 0; i < 13; i++)
    begin
      @(posedge core_clk);
      rxPin <= fr[i];
      repeat (((bitLen == 0) ? BIT_CLK : bitLen) - 1) @(posedge core_clk);
    end
  endtask
endmodule // uad_line_model

// ### bench/uad_top_tb.sv
// Self-checking bench for the address-detecting receiver.
// Assumes the register index map and bit layout of the constants header.
`timescale 1ns/1ps
`include "uad_consts.svh"
module uad_top_tb;
  import uad_pkg::*;
  logic      core_clk, sys_rst, regWrStb, regRdStb, rxPin;
  logic      rxAvailable, irq, txNineBit, syncClkMaster;
  uad_addr_t regAddr;
  uad_byte_t regWrData, regRdData, rv;
  int        fails, nCompared, bitLen;

  uad_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .rxPin(rxPin),
    .rxAvailable(rxAvailable), .irq(irq), .txNineBit(txNineBit), .syncClkMaster(syncClkMaster));
  uad_line_model #(.BIT_CLK(8)) line (.core_clk(core_clk), .rxPin(rxPin));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    nCompared++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input uad_addr_t a, input uad_byte_t d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge core_clk);
    regWrStb  <= 1'b0;
  endtask

  task automatic rchk(input string nm, input uad_addr_t a, input uad_byte_t exp);
    @(posedge core_clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1 rv = regRdData;
    chk(nm, exp, rv);
  endtask

  task automatic pins(input logic av, input logic iq);
    chk("rxAvailable", {7'h00, av}, {7'h00, rxAvailable});
    chk("irq", {7'h00, iq}, {7'h00, irq});
  endtask

  task automatic tx(input logic [8:0] ch, input logic nine, input logic stopLvl);
    line.send(ch, nine, stopLvl, bitLen);
    repeat (6) @(posedge core_clk);
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    finish_test;
  end

  initial
  begin
    sys_rst   = 1'b1;
    regAddr   = 3'h0;
    regWrData = 8'h00;
    regWrStb  = 1'b0;
    regRdStb  = 1'b0;
    fails     = 0;
    nCompared = 0;
    bitLen    = 0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      rchk("reset value", i[2:0], (i == 0) ? 8'h40 : ((i == 5) ? 8'h02 : 8'h00));
    pins(1'b0, 1'b0);
    done("reset");

    wr(`UAD_IDX_TX_STAT, 8'hd4);
    rchk("tx_status_control", `UAD_IDX_TX_STAT, 8'hd6);
    chk("txNineBit", 8'h01, {7'h00, txNineBit});
    chk("syncClkMaster", 8'h01, {7'h00, syncClkMaster});
    wr(`UAD_IDX_TX_STAT, 8'h84);
    repeat (2) @(posedge core_clk);
    #1 chk("txNineBit", 8'h00, {7'h00, txNineBit});
    chk("syncClkMaster", 8'h00, {7'h00, syncClkMaster});
    done("tx control");

    wr(`UAD_IDX_DIV_LOW, 8'h01);
    wr(`UAD_IDX_DIV_HIGH, 8'h00);
    wr(`UAD_IDX_BAUD_CTRL, 8'h08);
    wr(`UAD_IDX_TX_STAT, 8'h04);
    wr(`UAD_IDX_RX_STAT, 8'h80);
    wr(`UAD_IDX_INT_MASK, 8'h01);
    wr(`UAD_IDX_RX_STAT, 8'hc0);
    wr(`UAD_IDX_RX_STAT, 8'hc8);
    wr(`UAD_IDX_RX_STAT, 8'hd8);
    rchk("baud_control", `UAD_IDX_BAUD_CTRL, 8'h48);
    tx(9'h0a5, 1'b1, 1'b1);
    #1 pins(1'b0, 1'b0);
    rchk("int status", `UAD_IDX_INT_STAT, 8'h00);
    tx(9'h15a, 1'b1, 1'b1);
    #1 pins(1'b1, 1'b1);
    rchk("rx_status_control", `UAD_IDX_RX_STAT, 8'hd9);
    rchk("rx_data", `UAD_IDX_RX_DATA, 8'h5a);
    wr(`UAD_IDX_INT_STAT, 8'h01);
    #1 pins(1'b0, 1'b0);
    done("address mode");

    wr(`UAD_IDX_INT_MASK, 8'h00);
    tx(9'h1c3, 1'b1, 1'b1);
    #1 pins(1'b1, 1'b0);
    rchk("rx_data", `UAD_IDX_RX_DATA, 8'hc3);
    wr(`UAD_IDX_INT_STAT, 8'h01);
    wr(`UAD_IDX_INT_MASK, 8'h01);
    done("masked");

    wr(`UAD_IDX_RX_STAT, 8'hd0);
    tx(9'h011, 1'b1, 1'b1);
    tx(9'h122, 1'b1, 1'b1);
    #1 pins(1'b1, 1'b1);
    rchk("rx_status_control", `UAD_IDX_RX_STAT, 8'hd0);
    rchk("rx_data", `UAD_IDX_RX_DATA, 8'h11);
    rchk("rx_status_control", `UAD_IDX_RX_STAT, 8'hd1);
    rchk("rx_data", `UAD_IDX_RX_DATA, 8'h22);
    wr(`UAD_IDX_INT_STAT, 8'hff);
    done("data mode");

    tx(9'h033, 1'b1, 1'b1);
    tx(9'h044, 1'b1, 1'b1);
    tx(9'h055, 1'b1, 1'b1);
    rchk("rx_status_control", `UAD_IDX_RX_STAT, 8'hd2);
    tx(9'h066, 1'b1, 1'b1);
    rchk("int status", `UAD_IDX_INT_STAT, 8'h03);
    rchk("rx_data", `UAD_IDX_RX_DATA, 8'h33);
    rchk("rx_data", `UAD_IDX_RX_DATA, 8'h44);
    #1 chk("rxAvailable", 8'h00, {7'h00, rxAvailable});
    wr(`UAD_IDX_RX_STAT, 8'hc0);
    rchk("rx_status_control", `UAD_IDX_RX_STAT, 8'hc0);
    wr(`UAD_IDX_INT_STAT, 8'hff);
    rchk("int status", `UAD_IDX_INT_STAT, 8'h00);
    done("overrun");

    wr(`UAD_IDX_RX_STAT, 8'hd0);
    tx(9'h077, 1'b1, 1'b0);
    rchk("rx_status_control", `UAD_IDX_RX_STAT, 8'hd4);
    wr(`UAD_IDX_RX_DATA, 8'hff);
    rchk("rx_data", `UAD_IDX_RX_DATA, 8'h77);
    #1 pins(1'b0, 1'b1);
    wr(`UAD_IDX_RX_STAT, 8'h00);
    rchk("rx_status_control", `UAD_IDX_RX_STAT, 8'h00);
    done("framing and disable");

    wr(`UAD_IDX_INT_STAT, 8'hff);
    wr(`UAD_IDX_DIV_LOW, 8'h00);
    wr(`UAD_IDX_TX_STAT, 8'h00);
    wr(`UAD_IDX_RX_STAT, 8'h90);
    bitLen = 16;
    tx(9'h0b6, 1'b0, 1'b1);
    #1 pins(1'b1, 1'b1);
    rchk("rx_status_control", `UAD_IDX_RX_STAT, 8'h90);
    rchk("rx_data", `UAD_IDX_RX_DATA, 8'hb6);
    #1 pins(1'b0, 1'b1);
    done("eight bit");
    finish_test;
  end
endmodule // uad_top_tb
